/* hw/mdci_pkg.sv */
package mdci_pkg;

    // ***************************************************************
    // Register map
    // ***************************************************************
    localparam int          NUM_SLOTS       = 2;
    localparam logic [11:0] ADDR_RAW_EVENT  = 12'h000;
    localparam logic [11:0] ADDR_MASKED     = 12'h004;
    localparam logic [11:0] ADDR_ENABLE_SET = 12'h008;
    localparam logic [11:0] ADDR_ENABLE_CLR = 12'h00C;
    localparam logic [11:0] ADDR_CONTROL    = 12'h010;

    // ***************************************************************
    // Field positions and reset values
    // ***************************************************************
    localparam int          SLOT_LSB        = 0;
    localparam int          SLOT_MSB        = 1;
    localparam int          CTRL_TEST_BIT   = 0;
    localparam logic [1:0]  SLOT_RESET      = 2'h0;
    localparam logic [31:0] READ_ZERO       = 32'h0000_0000;

    // ***************************************************************
    // Bus access decode
    // ***************************************************************
    typedef enum logic [2:0] {
        MDCI_ACC_IDLE  = 3'h1,
        MDCI_ACC_WRITE = 3'h2,
        MDCI_ACC_READ  = 3'h4
    } mdci_acc_e;

endpackage

/* hw/mdci_slot_flag.sv */
`timescale 1ns/1ps

// One sticky event flag: a set in the same cycle as a clear wins.
module mdci_slot_flag (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic set_pulse,
    input  wire logic clear_pulse,
    output logic      flag
);
    logic flag_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= 1'b0;
        end else if (set_pulse) begin
            flag_reg <= 1'b1;
        end else if (clear_pulse) begin
            flag_reg <= 1'b0;
        end
    end

    assign flag = flag_reg;
endmodule

/* hw/mdci_apb_decode.sv */
`timescale 1ns/1ps

// APB access qualifier: the slave always answers with zero wait states.
module mdci_apb_decode (
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    output mdci_pkg::mdci_acc_e acc,
    output logic             mapped
);
    import mdci_pkg::*;

    always_comb begin
        acc = MDCI_ACC_IDLE;
        if (psel && penable) begin
            acc = pwrite ? MDCI_ACC_WRITE : MDCI_ACC_READ;
        end
    end

    assign mapped = (paddr == ADDR_RAW_EVENT) || (paddr == ADDR_MASKED) ||
                    (paddr == ADDR_ENABLE_SET) ||
                    (paddr == ADDR_ENABLE_CLR) || (paddr == ADDR_CONTROL);
endmodule

/* hw/mdci_irq_mask.sv */
`timescale 1ns/1ps

// Contract
// - A masked bit is one only when its event is pending and enabled.
// - A one written to a masked bit clears its event; zero does nothing.
// - A one in an enable-set write enables that slot; zero does nothing.
// - A slot whose enable bit is zero never shows in the masked status.
// - A one in an enable-clear write masks its slot; zero does nothing.
// - Bit 0 of each event and enable register is slot zero and bit 1 is slot one; control bit 0 is the test bit.
// - Bits 31 to 2 of every register read zero and ignore writes, except control bits 9 and 8, which raise events in test mode.
// - After reset all enable bits and all pending events are zero.
// - A raw event sets as its command ends; a write of one clears it.
module mdci_irq_mask #(
    parameter int SLOTS = mdci_pkg::NUM_SLOTS
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic [SLOTS-1:0] cmd_done_pulse,
    output logic                  cmd_done_irq
);
    import mdci_pkg::*;

    // ***************************************************************
    // Bus decode
    // ***************************************************************
    mdci_acc_e        acc;
    logic             mapped;
    logic             wr_hit;
    logic [SLOTS-1:0] wbits;
    logic [SLOTS-1:0] raw_clear;
    logic [SLOTS-1:0] raw_event;
    logic [SLOTS-1:0] enable_reg;
    logic [SLOTS-1:0] masked;
    logic [SLOTS-1:0] event_in;
    logic             test_mode_reg;
    logic [31:0]      rdata_next;
    logic [31:0]      prdata_reg;

    mdci_apb_decode u_decode (
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .acc     (acc),
        .mapped  (mapped)
    );

    assign wr_hit = (acc == MDCI_ACC_WRITE);
    assign wbits  = pwdata[SLOTS-1:0];

    // Unmapped addresses are flagged so that a stray driver write is seen.
    assign pready  = 1'b1;
    assign pslverr = (acc != MDCI_ACC_IDLE) && !mapped;

    // ***************************************************************
    // Control register
    // ***************************************************************
    // A software test bit lets the flags be exercised without the state
    // machine, which helps bring-up at the cost of one extra register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_mode_reg <= 1'b0;
        end else if (wr_hit && paddr == ADDR_CONTROL) begin
            test_mode_reg <= pwdata[CTRL_TEST_BIT];
        end
    end

    // ***************************************************************
    // Raw completion events
    // ***************************************************************
    genvar i;
    generate
        for (i = 0; i < SLOTS; i++) begin : g_slot
            assign raw_clear[i] = wr_hit && wbits[i] &&
                                  (paddr == ADDR_RAW_EVENT ||
                                   paddr == ADDR_MASKED);
            assign event_in[i]  = cmd_done_pulse[i] ||
                                  (test_mode_reg && wr_hit &&
                                   paddr == ADDR_CONTROL &&
                                   pwdata[i + 8]);
            mdci_slot_flag u_flag (
                .pclk        (pclk),
                .presetn     (presetn),
                .set_pulse   (event_in[i]),
                .clear_pulse (raw_clear[i]),
                .flag        (raw_event[i])
            );
        end
    endgenerate

    // ***************************************************************
    // Enable bits
    // ***************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_reg <= SLOTS'(SLOT_RESET);
        end else if (wr_hit && paddr == ADDR_ENABLE_SET) begin
            enable_reg <= enable_reg | wbits;
        end else if (wr_hit && paddr == ADDR_ENABLE_CLR) begin
            enable_reg <= enable_reg & ~wbits;
        end
    end

    assign masked = raw_event & enable_reg;

    assign cmd_done_irq = |masked;

    // ***************************************************************
    // Read data
    // ***************************************************************
    always_comb begin
        rdata_next = READ_ZERO;
        case (paddr)
            ADDR_RAW_EVENT:  rdata_next[SLOTS-1:0] = raw_event;
            ADDR_MASKED:     rdata_next[SLOTS-1:0] = masked;
            ADDR_ENABLE_SET: rdata_next[SLOTS-1:0] = enable_reg;
            ADDR_ENABLE_CLR: rdata_next[SLOTS-1:0] = enable_reg;
            ADDR_CONTROL:    rdata_next[CTRL_TEST_BIT] = test_mode_reg;
            default:         rdata_next = READ_ZERO;
        endcase
    end

    // Read data is captured in the setup cycle so it stands in the access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= READ_ZERO;
        end else if (psel && !penable && !pwrite) begin
            prdata_reg <= rdata_next;
        end
    end

    assign prdata = prdata_reg;
endmodule

/* bench/mdci_irq_mask_assertions.sv */
`timescale 1ns/1ps

module mdci_irq_mask_chk #(
    parameter int SLOTS = 2
) (
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      pwdata,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    input wire logic [SLOTS-1:0] cmd_done_pulse,
    input wire logic             cmd_done_irq
);
    // ****************************************
    // Helpers
    // ****************************************
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_en_all;
        wr && paddr == 12'h008 && pwdata[1:0] == 2'h3;
    endsequence
    sequence s_event;
        cmd_done_pulse != '0;
    endsequence
    chk_irq_raise: assert property (
        s_en_all ##1 s_event |-> ##[1:3] cmd_done_irq)
        else $error("irq missing after enabled event");
    chk_irq_clear: assert property (
        wr && paddr == 12'h00C && pwdata[1:0] == 2'h3 |=> !cmd_done_irq)
        else $error("irq stays after enable clear");
    chk_ack_clear: assert property (
        wr && paddr == 12'h004 && pwdata[1:0] == 2'h3 &&
        cmd_done_pulse == '0 |=> !cmd_done_irq)
        else $error("irq stays after status clear");
    chk_zero_keep: assert property (
        wr && (paddr == 12'h004 || paddr == 12'h00C) &&
        pwdata[1:0] == 2'h0 && cmd_done_irq |=> cmd_done_irq)
        else $error("zero write changed irq");
    chk_read_upper: assert property (
        acc && !pwrite |-> prdata[31:2] == 30'h0)
        else $error("upper read bits not zero");
    chk_read_masked: assert property (
        acc && !pwrite && paddr == 12'h004 && prdata[1:0] != 2'h0
        |-> cmd_done_irq)
        else $error("masked status set without irq");
    chk_unmapped_err: assert property (
        acc && paddr > 12'h010 |-> pready && pslverr)
        else $error("unmapped access without error");
    chk_reset_quiet: assert property (
        $rose(presetn) |-> !cmd_done_irq)
        else $error("irq high after reset");
endmodule

bind mdci_irq_mask mdci_irq_mask_chk #(
    .SLOTS (SLOTS)
) i_chk (
    .pclk           (pclk),
    .presetn        (presetn),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .prdata         (prdata),
    .pready         (pready),
    .pslverr        (pslverr),
    .cmd_done_pulse (cmd_done_pulse),
    .cmd_done_irq   (cmd_done_irq)
);

/* bench/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
    typedef struct packed {
        logic [1:0]  p;
        logic        w;
        logic [11:0] a;
        logic [31:0] d;
        logic        q;
    } mdci_row_s;

    logic        pclk           = 1'b0;
    logic        presetn        = 1'b0;
    logic        psel           = 1'b0;
    logic        penable        = 1'b0;
    logic        pwrite         = 1'b0;
    logic [11:0] paddr          = 12'h000;
    logic [31:0] pwdata         = 32'h0000_0000;
    logic [1:0]  cmd_done_pulse = 2'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    int          failures       = 0;
    int          checks         = 0;

    // Each row: pulse before the transfer, write flag, address, write data
    // or expected read data, and the interrupt level expected afterwards.
    mdci_row_s   rows [16]      = '{
        '{2'h0, 1'h0, 12'h004, 32'h0000_0000, 1'h0},
        '{2'h0, 1'h0, 12'h008, 32'h0000_0000, 1'h0},
        '{2'h1, 1'h0, 12'h000, 32'h0000_0001, 1'h0},
        '{2'h0, 1'h0, 12'h004, 32'h0000_0000, 1'h0},
        '{2'h0, 1'h1, 12'h008, 32'hFFFF_FFFE, 1'h0},
        '{2'h0, 1'h0, 12'h00C, 32'h0000_0002, 1'h0},
        '{2'h2, 1'h0, 12'h004, 32'h0000_0002, 1'h1},
        '{2'h0, 1'h1, 12'h00C, 32'hFFFF_FFFC, 1'h1},
        '{2'h0, 1'h1, 12'h004, 32'h0000_0001, 1'h1},
        '{2'h0, 1'h1, 12'h004, 32'h0000_0002, 1'h0},
        '{2'h0, 1'h0, 12'h000, 32'h0000_0000, 1'h0},
        '{2'h1, 1'h1, 12'h008, 32'h0000_0001, 1'h1},
        '{2'h0, 1'h0, 12'h004, 32'h0000_0001, 1'h1},
        '{2'h0, 1'h1, 12'h00C, 32'h0000_0003, 1'h0},
        '{2'h0, 1'h0, 12'h008, 32'h0000_0000, 1'h0},
        '{2'h0, 1'h0, 12'h040, 32'h0000_0000, 1'h0}
    };

    mdci_irq_mask i_dut (
        .pclk           (pclk),
        .presetn        (presetn),
        .psel           (psel),
        .penable        (penable),
        .pwrite         (pwrite),
        .paddr          (paddr),
        .pwdata         (pwdata),
        .prdata         (prdata),
        .pready         (pready),
        .pslverr        (pslverr),
        .cmd_done_pulse (cmd_done_pulse),
        .cmd_done_irq   (irq)
    );

    always #20 pclk = ~pclk;

    // ****************************************
    // Tasks
    // ****************************************
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // A wait for pready ends once pready is seen high; the watchdog ends one that never does.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task pulse(input logic [1:0] p);
        cmd_done_pulse <= p;
        @(posedge pclk);
        cmd_done_pulse <= 2'h0;
    endtask
    task final_report;
        if (failures == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #100us;
        failures++;
        final_report;
    end

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        foreach (rows[i]) begin
            pulse(rows[i].p);
            apb(rows[i].w, rows[i].a, rows[i].d);
            // The interrupt settles after the access edge; look one edge on.
            @(posedge pclk);
            check(irq, rows[i].q);
            check(err, rows[i].a > 12'h010);
            if (!rows[i].w) check(rd, rows[i].d);
        end
        apb(1'b1, 12'h008, 32'h0000_0003);
        pulse(2'h3);
        apb(1'b0, 12'h004, 32'h0000_0000);
        check(rd, 32'h0000_0003);
        apb(1'b1, 12'h004, 32'h0000_0003);
        apb(1'b0, 12'h000, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        // A completion held across the clearing write must win.
        cmd_done_pulse <= 2'h1;
        apb(1'b1, 12'h000, 32'h0000_0001);
        cmd_done_pulse <= 2'h0;
        apb(1'b0, 12'h000, 32'h0000_0000);
        check(rd, 32'h0000_0001);
        presetn <= 1'b0;
        @(posedge pclk);
        check(irq, 1'b0);
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h008, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        apb(1'b0, 12'h000, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        // Test mode fires slot one; with it off the strobe bits do nothing.
        apb(1'b1, 12'h010, 32'h0000_0001);
        apb(1'b1, 12'h010, 32'h0000_0201);
        apb(1'b1, 12'h010, 32'h0000_0000);
        apb(1'b1, 12'h010, 32'h0000_0100);
        apb(1'b0, 12'h000, 32'h0000_0000);
        check(rd, 32'h0000_0002);
        check(irq, 1'b0);
        final_report;
    end
endmodule
